// ==== pkg/cpreg_pkg.sv ====
// constants for the video preamp control register bank behind a two-wire
// serial slave port; assumes an oversampling system clock on I_CLK.
// Notes on behaviour
// - slave byte DCh writes, DDh reads
// - offsets 00-02 hold seven-bit channel gains
// - offset 03 holds seven-bit common contrast
// - offsets 04-07 hold four eight-bit converter codes
// - offset 08 bits 2:0 black level shift
// - offset 08 bits 4:3 overlay contrast
// - offset 09 bit 0 blanks video
// - offset 09 bit 1 powers analog down
// - offset 09 bit 3 halves converter range
// - offset 09 bit 4 mixes converter four
// - offset 0A bit 0 zero enables advance
// - offset 0B bits 2:0 bandwidth, reset 100
// - offset 0B bit 3 clamp polarity
// - soft reset reloads all other registers
// - soft reset spares the serial transaction
// - soft reset bit clears itself
// - advance mode stores bytes at next offset
// - reads start at written offset, advance
// - device acknowledges every byte addressed to it
package cpreg_pkg;
    localparam logic [6:0] SLAVE_ADDR   = 7'h6E; // byte DCh without rw bit
    localparam logic [3:0] OFS_RED      = 4'h0;
    localparam logic [3:0] OFS_BLUE     = 4'h1;
    localparam logic [3:0] OFS_GREEN    = 4'h2;
    localparam logic [3:0] OFS_CONTRAST = 4'h3;
    localparam logic [3:0] OFS_CONV1    = 4'h4;
    localparam logic [3:0] OFS_OVERLAY  = 4'h8;
    localparam logic [3:0] OFS_GLOBAL   = 4'h9;
    localparam logic [3:0] OFS_ADVANCE  = 4'hA;
    localparam logic [3:0] OFS_CLAMP    = 4'hB;
    localparam logic [3:0] OFS_SRESET   = 4'hF;
    localparam logic [7:0] RST_GAIN     = 8'h60;
    localparam logic [7:0] RST_CONV     = 8'h80;
    localparam logic [7:0] RST_OVERLAY  = 8'h15;
    localparam logic [7:0] RST_GLOBAL   = 8'h00;
    localparam logic [7:0] RST_ADVANCE  = 8'h00;
    localparam logic [7:0] RST_CLAMP    = 8'h04;
    localparam logic [7:0] MSK_GAIN     = 8'h7F; // writable bits per register
    localparam logic [7:0] MSK_CONV     = 8'hFF;
    localparam logic [7:0] MSK_OVERLAY  = 8'h1F;
    localparam logic [7:0] MSK_GLOBAL   = 8'h3F;
    localparam logic [7:0] MSK_ADVANCE  = 8'h03;
    localparam logic [7:0] MSK_CLAMP    = 8'h0F;
    localparam int         GLB_BLANK    = 0;
    localparam int         GLB_PSAVE    = 1;
    localparam int         GLB_HALF     = 3;
    localparam int         GLB_MIX      = 4;
    localparam int         ADV_DISABLE  = 0;
    localparam int         CLP_POL      = 3;
    typedef enum logic [2:0] {
        CPREG_IDLE, CPREG_ADDR, CPREG_ACK, CPREG_WRX, CPREG_RDX,
        CPREG_RDACK, CPREG_IGNORE
    } cpreg_state_t;
endpackage

// ==== rtl/cpreg_bank.sv ====
// register bank with a two-wire serial slave port; SCL and SDA input
// levels are sampled as synchronous to I_CLK, which must oversample SCL.
`timescale 1ns/10ps
module cpreg_bank (
    input  wire logic       I_CLK,
    input  wire logic       I_RST_B,
    input  wire logic       I_SCL,
    input  wire logic       I_SDA,
    output logic            O_SDA_OE,
    output logic [6:0]      O_RED_GAIN,
    output logic [6:0]      O_BLUE_GAIN,
    output logic [6:0]      O_GREEN_GAIN,
    output logic [6:0]      O_CONTRAST_GAIN,
    output logic [31:0]     O_DAC_LEVEL,
    output logic [2:0]      O_BLACK_LEVEL_SHIFT,
    output logic [1:0]      O_OVERLAY_CONTRAST,
    output logic            O_BLANK_VIDEO,
    output logic            O_POWER_SAVE,
    output logic            O_DAC123_HALF_RANGE,
    output logic            O_CONVERTER_FOUR_LEVEL_MIX_ENABLE,
    output logic            O_AUTO_ADVANCE_DISABLE,
    output logic [2:0]      O_BANDWIDTH_SELECT,
    output logic            O_CLAMP_POLARITY
);
    logic [7:0]   regs_ff [0:11];  // offsets 00 to 0B
    logic         scl_ff;          // previous line levels
    logic         sda_ff;
    cpreg_pkg::cpreg_state_t state_ff;
    logic [7:0]   shift_ff;        // byte being received or sent
    logic [3:0]   bitcnt_ff;       // bits done in current byte
    logic         got_ofs_ff;      // offset byte already taken
    logic         rw_ff;           // current transfer reads
    logic [3:0]   ofs_ff;          // register pointer
    logic         soft_reset_trigger_ff;         // soft reset pulse, bit of 0Fh
    logic         wr_stb;          // data byte complete in write
    logic         ofs_stb;         // offset byte complete
    logic         adv_stb;         // pointer advance after a byte
    logic         start_c;
    logic         stop_c;
    logic         rise_c;
    logic         fall_c;
    logic [7:0]   rd_data;

    // line events, taken from sampled levels
    assign start_c = scl_ff && I_SCL && sda_ff && !I_SDA;
    assign stop_c  = scl_ff && I_SCL && !sda_ff && I_SDA;
    assign rise_c  = !scl_ff && I_SCL;
    assign fall_c  = scl_ff && !I_SCL;

    // readback with reserved bits forced low
    always_comb begin
        rd_data = 8'h00; // unmapped 0C-0E and 0F read zero
        if (ofs_ff <= cpreg_pkg::OFS_CLAMP) begin
            rd_data = regs_ff[ofs_ff];
        end
    end

    // previous samples for edge detection
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_ff <= I_SCL;
            sda_ff <= I_SDA;
        end
    end

    // serial slave engine; soft reset never touches it
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_ff   <= cpreg_pkg::CPREG_IDLE;
            shift_ff   <= 8'h00;
            bitcnt_ff  <= 4'h0;
            got_ofs_ff <= 1'b0;
            rw_ff      <= 1'b0;
            O_SDA_OE   <= 1'b0;
        end else if (start_c) begin
            // a repeated start also lands here
            state_ff   <= cpreg_pkg::CPREG_ADDR;
            bitcnt_ff  <= 4'h0;
            got_ofs_ff <= 1'b0;
            O_SDA_OE   <= 1'b0;
        end else if (stop_c) begin
            state_ff <= cpreg_pkg::CPREG_IDLE;
            O_SDA_OE <= 1'b0;
        end else begin
            case (state_ff)
                cpreg_pkg::CPREG_ADDR, cpreg_pkg::CPREG_WRX: begin
                    if (rise_c) begin
                        shift_ff  <= {shift_ff[6:0], I_SDA};
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                    end else if (fall_c && bitcnt_ff == 4'h8) begin
                        bitcnt_ff <= 4'h0;
                        if (state_ff == cpreg_pkg::CPREG_ADDR) begin
                            if (shift_ff[7:1] == cpreg_pkg::SLAVE_ADDR) begin
                                rw_ff    <= shift_ff[0];
                                O_SDA_OE <= 1'b1;
                                state_ff <= cpreg_pkg::CPREG_ACK;
                            end else begin
                                state_ff <= cpreg_pkg::CPREG_IGNORE;
                            end
                        end else begin
                            got_ofs_ff <= 1'b1;
                            O_SDA_OE   <= 1'b1;
                            state_ff   <= cpreg_pkg::CPREG_ACK;
                        end
                    end
                end
                cpreg_pkg::CPREG_ACK: begin
                    // after the acknowledge clock: release on write, drive first bit on read
                    if (fall_c) begin
                        if (rw_ff) begin
                            shift_ff <= rd_data;
                            O_SDA_OE <= !rd_data[7];
                            bitcnt_ff <= 4'h1;
                            state_ff <= cpreg_pkg::CPREG_RDX;
                        end else begin
                            O_SDA_OE <= 1'b0;
                            state_ff <= cpreg_pkg::CPREG_WRX;
                        end
                    end
                end
                cpreg_pkg::CPREG_RDX: begin
                    if (fall_c) begin
                        if (bitcnt_ff == 4'h8) begin
                            O_SDA_OE <= 1'b0; // master acknowledges
                            state_ff <= cpreg_pkg::CPREG_RDACK;
                        end else begin
                            shift_ff  <= {shift_ff[6:0], 1'b0};
                            O_SDA_OE  <= !shift_ff[6];
                            bitcnt_ff <= bitcnt_ff + 4'h1;
                        end
                    end
                end
                cpreg_pkg::CPREG_RDACK: begin
                    if (rise_c) begin
                        // high sample means no acknowledge: stop sending
                        state_ff <= I_SDA ? cpreg_pkg::CPREG_IGNORE
                                          : cpreg_pkg::CPREG_ACK;
                    end
                end
                cpreg_pkg::CPREG_IDLE, cpreg_pkg::CPREG_IGNORE: begin
                    O_SDA_OE <= 1'b0;
                end
                default: begin
                    state_ff <= cpreg_pkg::CPREG_IDLE;
                end
            endcase
        end
    end

    // byte completion strobes seen by the register side
    assign ofs_stb = !start_c && !stop_c && fall_c && bitcnt_ff == 4'h8
                     && state_ff == cpreg_pkg::CPREG_WRX && !got_ofs_ff;
    assign wr_stb  = !start_c && !stop_c && fall_c && bitcnt_ff == 4'h8
                     && state_ff == cpreg_pkg::CPREG_WRX && got_ofs_ff;
    assign adv_stb = wr_stb || (!start_c && !stop_c && rise_c
                     && state_ff == cpreg_pkg::CPREG_RDACK);

    // register pointer
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ofs_ff <= 4'h0;
        end else if (ofs_stb) begin
            ofs_ff <= shift_ff[3:0];
        end else if (adv_stb &&
                     !regs_ff[cpreg_pkg::OFS_ADVANCE][cpreg_pkg::ADV_DISABLE])
        begin
            ofs_ff <= ofs_ff + 4'h1;
        end
        // advance disabled: pointer holds
    end

    // soft reset: one-cycle pulse, reads back zero after
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            soft_reset_trigger_ff <= 1'b0;
        end else begin
            soft_reset_trigger_ff <= wr_stb && ofs_ff == cpreg_pkg::OFS_SRESET
                       && shift_ff[0];
        end
    end

    // register storage, one generate entry per offset
    for (genvar g = 0; g < 12; g++) begin : g_reg
        localparam logic [3:0] OFS = 4'(g);
        localparam logic [7:0] RST =
            (g <= 3) ? cpreg_pkg::RST_GAIN :
            (g <= 7) ? cpreg_pkg::RST_CONV :
            (g == 8) ? cpreg_pkg::RST_OVERLAY :
            (g == 9) ? cpreg_pkg::RST_GLOBAL :
            (g == 10) ? cpreg_pkg::RST_ADVANCE : cpreg_pkg::RST_CLAMP;
        localparam logic [7:0] MSK =
            (g <= 3) ? cpreg_pkg::MSK_GAIN :
            (g <= 7) ? cpreg_pkg::MSK_CONV :
            (g == 8) ? cpreg_pkg::MSK_OVERLAY :
            (g == 9) ? cpreg_pkg::MSK_GLOBAL :
            (g == 10) ? cpreg_pkg::MSK_ADVANCE : cpreg_pkg::MSK_CLAMP;
        always_ff @(posedge I_CLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
                regs_ff[g] <= RST;
            end else if (soft_reset_trigger_ff) begin
                regs_ff[g] <= RST;
            end else if (wr_stb && ofs_ff == OFS) begin
                regs_ff[g] <= shift_ff & MSK;
            end
        end
    end

    // control outputs, registered copies of the fields
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RED_GAIN             <= cpreg_pkg::RST_GAIN[6:0];
            O_BLUE_GAIN            <= cpreg_pkg::RST_GAIN[6:0];
            O_GREEN_GAIN           <= cpreg_pkg::RST_GAIN[6:0];
            O_CONTRAST_GAIN        <= cpreg_pkg::RST_GAIN[6:0];
            O_DAC_LEVEL            <= {4{cpreg_pkg::RST_CONV}};
            O_BLACK_LEVEL_SHIFT    <= cpreg_pkg::RST_OVERLAY[2:0];
            O_OVERLAY_CONTRAST     <= cpreg_pkg::RST_OVERLAY[4:3];
            O_BLANK_VIDEO          <= 1'b0;
            O_POWER_SAVE           <= 1'b0;
            O_DAC123_HALF_RANGE    <= 1'b0;
            O_CONVERTER_FOUR_LEVEL_MIX_ENABLE      <= 1'b0;
            O_AUTO_ADVANCE_DISABLE <= 1'b0;
            O_BANDWIDTH_SELECT     <= cpreg_pkg::RST_CLAMP[2:0];
            O_CLAMP_POLARITY       <= 1'b0;
        end else begin
            O_RED_GAIN          <= regs_ff[cpreg_pkg::OFS_RED][6:0];
            O_BLUE_GAIN         <= regs_ff[cpreg_pkg::OFS_BLUE][6:0];
            O_GREEN_GAIN        <= regs_ff[cpreg_pkg::OFS_GREEN][6:0];
            O_CONTRAST_GAIN     <= regs_ff[cpreg_pkg::OFS_CONTRAST][6:0];
            O_DAC_LEVEL         <= {regs_ff[7], regs_ff[6], regs_ff[5],
                                    regs_ff[cpreg_pkg::OFS_CONV1]};
            O_BLACK_LEVEL_SHIFT <= regs_ff[cpreg_pkg::OFS_OVERLAY][2:0];
            O_OVERLAY_CONTRAST  <= regs_ff[cpreg_pkg::OFS_OVERLAY][4:3];
            O_BLANK_VIDEO       <=
                regs_ff[cpreg_pkg::OFS_GLOBAL][cpreg_pkg::GLB_BLANK];
            O_POWER_SAVE        <=
                regs_ff[cpreg_pkg::OFS_GLOBAL][cpreg_pkg::GLB_PSAVE];
            O_DAC123_HALF_RANGE <=
                regs_ff[cpreg_pkg::OFS_GLOBAL][cpreg_pkg::GLB_HALF];
            O_CONVERTER_FOUR_LEVEL_MIX_ENABLE   <=
                regs_ff[cpreg_pkg::OFS_GLOBAL][cpreg_pkg::GLB_MIX];
            O_AUTO_ADVANCE_DISABLE <=
                regs_ff[cpreg_pkg::OFS_ADVANCE][cpreg_pkg::ADV_DISABLE];
            O_BANDWIDTH_SELECT  <= regs_ff[cpreg_pkg::OFS_CLAMP][2:0];
            O_CLAMP_POLARITY    <=
                regs_ff[cpreg_pkg::OFS_CLAMP][cpreg_pkg::CLP_POL];
        end
    end
endmodule

// ==== testbench/cpreg_master.sv ====
// behavioural two-wire bus master driving the register bank
// assumes a pull-up on sda; drives pins at the falling clock edge
`timescale 1ns/10ps
module cpreg_master (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    // idle bus: both lines released high
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic hold();
        repeat (5) @(negedge i_clk);
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start();
        o_sda_oe = 1'b0;
        hold();
        o_scl = 1'b1;
        hold();
        o_sda_oe = 1'b1;
        hold();
        o_scl = 1'b0;
        hold();
    endtask
    // stop: sda rises while scl high, bus left released
    task automatic stop();
        o_sda_oe = 1'b1;
        hold();
        o_scl = 1'b1;
        hold();
        o_sda_oe = 1'b0;
        hold();
    endtask
    // data changes only while scl is low; a one is a released line
    task automatic bit_io(input logic b, output logic r);
        o_sda_oe = ~b;
        hold();
        o_scl = 1'b1;
        hold();
        r = i_sda;
        o_scl = 1'b0;
        hold();
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic mack,
                           output logic [7:0] r, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], x);
            r[i] = x;
        end
        bit_io(mack, ack);
    endtask
endmodule

// ==== testbench/cpreg_properties.sv ====
// pin timing and reset-value assertions for the preamp register bank
// assumes I_CLK oversamples SCL and every output is registered
`timescale 1ns/10ps
module cpreg_properties (
    input wire logic        I_CLK,
    input wire logic        I_RST_B,
    input wire logic        I_SCL,
    input wire logic        O_SDA_OE,
    input wire logic [6:0]  O_RED_GAIN,
    input wire logic [6:0]  O_CONTRAST_GAIN,
    input wire logic [31:0] O_DAC_LEVEL,
    input wire logic [2:0]  O_BLACK_LEVEL_SHIFT,
    input wire logic [1:0]  O_OVERLAY_CONTRAST,
    input wire logic [2:0]  O_BANDWIDTH_SELECT,
    input wire logic        O_BLANK_VIDEO
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    // first edge after reset lets go
    sequence s_released;
        $rose(I_RST_B);
    endsequence
    // three I_CLK cycles of the serial clock high
    sequence s_scl_high3;
        I_SCL[*3];
    endsequence
    a_reset_gains: assert property (s_released |->
        O_RED_GAIN == 7'h60 && O_CONTRAST_GAIN == 7'h60)
        else $error("gain reset value wrong");
    a_reset_dacs: assert property (s_released |->
        O_DAC_LEVEL == 32'h80808080) else $error("dac reset value wrong");
    a_reset_fields: assert property (s_released |->
        O_BLACK_LEVEL_SHIFT == 3'h5 && O_OVERLAY_CONTRAST == 2'h2)
        else $error("offset field reset value wrong");
    a_reset_band: assert property (s_released |->
        O_BANDWIDTH_SELECT == 3'h4 && !O_BLANK_VIDEO)
        else $error("bandwidth reset value wrong");
    a_ack_rise_low: assert property ($rose(O_SDA_OE) |-> !I_SCL)
        else $error("sda pulled while scl high");
    a_ack_fall_low: assert property ($fell(O_SDA_OE) |-> !I_SCL)
        else $error("sda released while scl high");
    a_ack_holds_high: assert property ($rose(I_SCL) && O_SDA_OE |->
        O_SDA_OE throughout s_scl_high3) else $error("sda dropped early");
    a_dac_update_low: assert property ($changed(O_DAC_LEVEL) |->
        !$past(I_SCL)) else $error("dac changed outside byte end");
    a_blank_update_low: assert property ($changed(O_BLANK_VIDEO) |->
        !$past(I_SCL) && !I_SCL) else $error("blank changed mid bit");
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the register bank behind the serial port
// assumes the master model and checker are compiled beforehand
`timescale 1ns/10ps
module testbench;
    logic             clk, rst_b, scl, m_oe, d_oe;
    wire logic        sda = ~(m_oe | d_oe); // open drain with pull-up
    logic [6:0]       red, blue, green, cont;
    logic [31:0]      dac, q;
    logic [2:0]       shift, bw;
    logic [1:0]       ovl;
    logic             blank, psave, half, mix, adv, pol, a;
    logic [7:0]       r;
    int               n_mismatch = 0, n_tests = 0;
    wire logic [13:0] misc = {bw, pol, ovl, shift, mix, half, psave, blank,
                              adv};
    cpreg_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    cpreg_bank dut (.I_CLK(clk), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda),
        .O_SDA_OE(d_oe), .O_RED_GAIN(red), .O_BLUE_GAIN(blue),
        .O_GREEN_GAIN(green), .O_CONTRAST_GAIN(cont), .O_DAC_LEVEL(dac),
        .O_BLACK_LEVEL_SHIFT(shift), .O_OVERLAY_CONTRAST(ovl),
        .O_BLANK_VIDEO(blank), .O_POWER_SAVE(psave),
        .O_DAC123_HALF_RANGE(half), .O_CONVERTER_FOUR_LEVEL_MIX_ENABLE(mix),
        .O_AUTO_ADVANCE_DISABLE(adv), .O_BANDWIDTH_SELECT(bw),
        .O_CLAMP_POLARITY(pol));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    // one byte from the master; the device must pull the ack slot low
    task automatic tx(input logic [7:0] d);
        logic [7:0] x;
        logic k;
        m.byte_io(d, 1'b1, x, k);
        chk("ack", 32'h0, {31'h0, k});
    endtask
    // write n bytes from d, most significant first, at offset o
    task automatic wr(input logic [7:0] o, input int n, input logic [31:0] d);
        m.start();
        tx(8'hDC);
        tx(o);
        for (int i = n - 1; i >= 0; i--) tx(d[i*8 +: 8]);
        m.stop();
    endtask
    // offset-only write, then read n bytes and compare
    task automatic rc(input logic [7:0] o, input int n, input logic [31:0] e);
        logic [7:0] b;
        logic k;
        wr(o, 0, 32'h0);
        m.start();
        tx(8'hDD);
        q = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            m.byte_io(8'hFF, i == 0, b, k);
            q = {q[23:0], b};
        end
        m.stop();
        chk("readback", e, q);
    endtask
    initial begin
        rst_b = 1'b0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        rc(8'h00, 4, 32'h60606060);
        rc(8'h04, 4, 32'h80808080);
        rc(8'h08, 4, 32'h15000004);
        rc(8'h0C, 4, 32'h00000000);
        chk("fields", 32'h22A0, misc);
        $display("test reset values done");
        wr(8'h00, 4, 32'hFF817FAA);
        rc(8'h00, 4, 32'h7F017F2A);
        chk("gains", 32'h0FE07FAA, {red, blue, green, cont});
        wr(8'h04, 4, 32'h01234567);
        chk("dac", 32'h67452301, dac);
        wr(8'h08, 1, 32'hFF);
        rc(8'h08, 1, 32'h1F);
        chk("offset", 32'h1F, {ovl, shift});
        for (int b = 0; b < 5; b++) begin
            if (b != 2) begin
                wr(8'h09, 1, 32'h1 << b);
                chk("global", 32'h1 << b, {mix, half, 1'b0, psave, blank});
            end
        end
        wr(8'h09, 1, 32'hC0);
        rc(8'h09, 1, 32'h00);
        wr(8'h0B, 1, 32'h0F);
        chk("clamp", 32'hF, {pol, bw});
        wr(8'h0C, 1, 32'hFF);
        rc(8'h0C, 1, 32'h00);
        $display("test field writes done");
        wr(8'h0A, 1, 32'h01);
        chk("advance", 32'h1, {31'h0, adv});
        wr(8'h04, 3, 32'hAABBCC);
        rc(8'h04, 2, 32'hCCCC);
        wr(8'h0A, 1, 32'h00);
        rc(8'h05, 1, 32'h23);
        $display("test fixed pointer done");
        // reset mid transfer; the next byte wraps to offset 00
        wr(8'h0F, 2, 32'h0133);
        rc(8'h0F, 2, 32'h0033);
        rc(8'h01, 4, 32'h60606080);
        chk("dac", 32'h80808080, dac);
        chk("fields", 32'h22A0, misc);
        $display("test soft reset done");
        m.start();
        m.byte_io(8'hD8, 1'b1, r, a);
        m.stop();
        chk("nack", 32'h1, {31'h0, a});
        $display("test foreign address done");
        results();
    end
    // watchdog: the sequence needs well under this span
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
endmodule
bind cpreg_bank cpreg_properties u_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .I_SCL(I_SCL), .O_SDA_OE(O_SDA_OE), .O_RED_GAIN(O_RED_GAIN),
    .O_CONTRAST_GAIN(O_CONTRAST_GAIN), .O_DAC_LEVEL(O_DAC_LEVEL),
    .O_BLACK_LEVEL_SHIFT(O_BLACK_LEVEL_SHIFT),
    .O_OVERLAY_CONTRAST(O_OVERLAY_CONTRAST),
    .O_BANDWIDTH_SELECT(O_BANDWIDTH_SELECT), .O_BLANK_VIDEO(O_BLANK_VIDEO));
